/* File: mhl_pkg.sv */
// Package with the host latch bank address map, fields and constants
package mhl_pkg;
   // ----------------------------------------------------------------
   // Address map
   // ----------------------------------------------------------------
   localparam logic [15:0] UART_DATA_PORT = 16'hd1c0;
   localparam logic [15:0] UART_RESET_AND_STATUS = 16'hd1c1;
   localparam logic [15:0] UART_COMMAND = 16'hd1c2;
   localparam logic [15:0] UART_CONTROL = 16'hd1c3;
   localparam logic [15:0] RAM_PAGE_LOW_AND_BUS_RESET = 16'hd1e0;
   localparam logic [15:0] PORT_DATA = 16'hd1e1;
   localparam logic [15:0] GENERAL_OUT_IN = 16'hd1e2;
   localparam logic [15:0] ROM_SELECT_AND_IRQ_SENSE = 16'hd1e3;
   localparam logic [15:0] RAM_WINDOW_BASE = 16'hd600;
   localparam logic [15:0] ROM_WINDOW_BASE = 16'hd800;
   // Regions: upper address bits that select a block, low bits that select a register
   localparam int REGION_LSB = 5;
   localparam int REG_SEL_W = 2;
   localparam int WIN_LSB = 8;
   localparam int ROM_LSB = 11;
   // ----------------------------------------------------------------
   // General purpose output fields
   // ----------------------------------------------------------------
   localparam int GPO_HI_ADDR_LSB = 0;
   localparam int GPO_HI_ADDR_W = 4;
   localparam int GPO_SEL_BIT = 4;
   localparam int GPO_RAM_EN_BIT = 5;
   localparam int GPO_STROBE_BIT = 6;
   localparam int GPO_PIRQ_EN_BIT = 7;
   localparam logic [7:0] GPO_RESET = 8'h00;
   // General purpose input fields
   localparam int GPI_CD_BIT = 0;
   localparam int GPI_MSG_BIT = 1;
   localparam int GPI_IO_BIT = 2;
   localparam int GPI_FAULT_BIT = 4;
   localparam int GPI_BSY_BIT = 5;
   localparam int GPI_PBUSY_BIT = 6;
   localparam int GPI_REQ_BIT = 7;
   // ROM select and sense fields
   localparam int ROM_SEL_LSB = 2;
   localparam int ROM_SEL_W = 4;
   localparam logic [7:0] ROM_SEL_RESET = 8'h00;
   localparam int SNS_DCD_BIT = 0;
   localparam int SNS_DSR_BIT = 1;
   localparam int SNS_CTS_BIT = 2;
   localparam int SNS_PIRQ_BIT = 3;
   localparam int SNS_IRQ_BIT = 4;
   localparam logic [7:0] PAGE_RESET = 8'h00;
   localparam logic [7:0] DATA_RESET = 8'h00;
   // UART register count behind the four decoded locations
   localparam int UART_REGS = 4;
   // Local clock: refresh keeps running while host clock is absent
   localparam int HOST_CLK_TIMEOUT_NS = 2000;
   localparam int CLK_PERIOD_NS = 50;
   localparam int HOST_CLK_TIMEOUT_CYC = HOST_CLK_TIMEOUT_NS / CLK_PERIOD_NS;
   localparam int REFRESH_PERIOD_NS = 15600;
   localparam int REFRESH_CYC = REFRESH_PERIOD_NS / CLK_PERIOD_NS;
   localparam int REFRESH_CNT_W = 10;
   localparam int ROW_W = 9;
endpackage

/* File: mhl_uart_regs.sv */
// Four-location register file standing in for the serial controller
`timescale 1ns/1ps
`default_nettype none
module mhl_uart_regs
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic wr,
   input wire logic rd,
   input wire logic [1:0] sel,
   input wire logic [7:0] wdata,
   input wire logic [7:0] rx_data,
   input wire logic [7:0] status_in,
   input wire logic irq_set,
   output logic [7:0] rdata,
   output logic tx_load,
   output logic prog_reset,
   output logic irq
);
   import mhl_pkg::*;
   logic [7:0] mem_reg [UART_REGS];
   logic irq_reg;

   // ----------------------------------------------------------------
   // Storage and read register
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         for (int i = 0; i < UART_REGS; i++)
            mem_reg[i] <= 8'h00;
      end
      else if (wr && sel != 2'h1)
      begin
         mem_reg[sel] <= wdata;
      end
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         rdata <= 8'h00;
      else if (rd)
      begin
         case (sel)
            2'h0: rdata <= rx_data;
            2'h1: rdata <= {irq_reg, status_in[6:0]};
            default: rdata <= mem_reg[sel];
         endcase
      end
   end

   // Status read clears the interrupt; a new event wins over the clear
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         irq_reg <= 1'b0;
      else if (irq_set)
         irq_reg <= 1'b1;
      else if ((rd && sel == 2'h1) || (wr && sel == 2'h1))
         irq_reg <= 1'b0;
   end

   assign tx_load = wr && sel == 2'h0;
   assign prog_reset = wr && sel == 2'h1;
   assign irq = irq_reg;
endmodule
`default_nettype wire

/* File: mhl_latch_bank.sv */
// Host latch bank: printer/SCSI latches, RAM window, ROM select, sense
//
// Overview of operation
// - Reading page latch, or reset, asserts bus reset
// - Reading general inputs releases bus reset
// - Drive data pins only while I/O high
// - Printer busy active high at input bit 6
// - Printer fault active low at input bit 4
// - Page latch write loads window address 15-8
// - Data write: printer plain, SCSI inverted
// - Data read returns SCSI lines inverted
// - Output latch: high address, select, RAM, strobe, irq
// - Input read returns SCSI and printer status lines
// - ROM select one-hot bits 5-2, zero disables
// - Sense read: modem lines, printer and card irq
// - Four UART locations; status read clears interrupt
// - RAM address from high, page, host low bits
// - RAM access and LED gated by bit 5
// - Refresh continues on local clock without host
// - Printer irq when enabled and printer not busy
// - Sense bit 4 on irq, bit 3 printer
// - Selected 2K ROM bank mapped at D800-DFFF
// - Each block decodes four registers, seven shadows
// - Data access sets ACK, REQ high clears it
// - SCSI status inputs reported at raw pin levels
// - UART modem inputs grounded, sensed via latch
`timescale 1ns/1ps
`default_nettype none
module mhl_latch_bank
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic host_clk_present,
   input wire logic [15:0] host_addr,
   input wire logic host_rd,
   input wire logic host_wr,
   input wire logic [7:0] host_wdata,
   output logic [7:0] host_rdata,
   output logic host_rdata_valid,
   input wire logic [7:0] scsi_data_in,
   output logic [7:0] scsi_data_out,
   output logic scsi_data_oe,
   output logic [7:0] prn_data,
   output logic prn_data_oe,
   input wire logic scsi_cd_n,
   input wire logic scsi_msg_n,
   input wire logic scsi_io_n,
   input wire logic scsi_bsy_n,
   input wire logic scsi_req_n,
   output logic scsi_ack_n,
   output logic scsi_rst_n,
   output logic scsi_sel_n,
   output logic prn_strobe_n,
   input wire logic prn_busy,
   input wire logic prn_fault_n,
   input wire logic ser_dcd,
   input wire logic ser_dsr,
   input wire logic ser_cts,
   output logic uart_dcd,
   output logic uart_dsr,
   output logic uart_cts,
   input wire logic [7:0] uart_rx_data,
   input wire logic [7:0] uart_status,
   input wire logic uart_event,
   output logic uart_tx_load,
   output logic uart_prog_reset,
   output logic [19:0] ram_addr,
   output logic ram_sel,
   output logic ram_wr,
   output logic [7:0] ram_wdata,
   input wire logic [7:0] ram_rdata,
   output logic ram_refresh,
   output logic [8:0] ram_refresh_row,
   output logic led_on,
   output logic [3:0] rom_bank_sel,
   output logic [10:0] rom_addr,
   input wire logic [7:0] rom_rdata,
   output logic irq_n
);
   import mhl_pkg::*;

   typedef enum logic [1:0] {MHL_NONE, MHL_UART, MHL_LATCH, MHL_WIN} mhl_e;

   logic [7:0] page_reg;
   logic [7:0] data_reg;
   logic [7:0] gpo_reg;
   logic [7:0] rom_sel_reg;
   logic bus_rst_reg;
   logic ack_reg;
   logic [7:0] rdata_reg;
   logic rvalid_reg;
   logic [REFRESH_CNT_W-1:0] ref_cnt_reg;
   logic [ROW_W-1:0] row_reg;
   logic [7:0] uart_rdata;
   logic uart_irq;
   logic uart_rd;
   logic uart_wr;
   logic acc;
   logic [1:0] rsel;
   logic pirq;
   logic card_irq;
   logic rom_hit;
   mhl_e region;

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   // Compare an address against a block base, ignoring low bits
   function automatic logic in_block(input logic [15:0] a,
                                     input logic [15:0] base,
                                     input int lsb);
      in_block = (a >> lsb) == (base >> lsb);
   endfunction

   always_comb
   begin
      if (in_block(host_addr, UART_DATA_PORT, REGION_LSB))
         region = MHL_UART;
      else if (in_block(host_addr, RAM_PAGE_LOW_AND_BUS_RESET, REGION_LSB))
         region = MHL_LATCH;
      else if (in_block(host_addr, RAM_WINDOW_BASE, WIN_LSB))
         region = MHL_WIN;
      else
         region = MHL_NONE;
   end

   assign rsel = host_addr[REG_SEL_W-1:0];
   assign acc = host_rd || host_wr;
   assign uart_rd = host_rd && region == MHL_UART;
   assign uart_wr = host_wr && region == MHL_UART;
   assign rom_hit = in_block(host_addr, ROM_WINDOW_BASE, ROM_LSB)
                    && rom_sel_reg[ROM_SEL_LSB +: ROM_SEL_W] != 4'h0;

   // ----------------------------------------------------------------
   // Write latches
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         page_reg <= PAGE_RESET;
      else if (host_wr && region == MHL_LATCH && rsel == 2'h0)
         page_reg <= host_wdata;
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         data_reg <= DATA_RESET;
      else if (host_wr && region == MHL_LATCH && rsel == 2'h1)
         data_reg <= host_wdata;
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         gpo_reg <= GPO_RESET;
      else if (host_wr && region == MHL_LATCH && rsel == 2'h2)
         gpo_reg <= host_wdata;
   end

   // Software keeps this one-hot; hardware does not police it
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         rom_sel_reg <= ROM_SEL_RESET;
      else if (host_wr && region == MHL_LATCH && rsel == 2'h3)
         rom_sel_reg <= host_wdata;
   end

   // ----------------------------------------------------------------
   // Bus reset and ACK handshake
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         bus_rst_reg <= 1'b1;
      else if (host_rd && region == MHL_LATCH && rsel == 2'h0)
         bus_rst_reg <= 1'b1;
      else if (host_rd && region == MHL_LATCH && rsel == 2'h2)
         bus_rst_reg <= 1'b0;
   end

   // Set wins over the clear by the peripheral
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         ack_reg <= 1'b0;
      else if (acc && region == MHL_LATCH && rsel == 2'h1)
         ack_reg <= 1'b1;
      else if (scsi_req_n)
         ack_reg <= 1'b0;
   end

   assign scsi_rst_n = ~(bus_rst_reg || rst);
   assign scsi_ack_n = ~ack_reg;

   // ----------------------------------------------------------------
   // Port outputs
   // ----------------------------------------------------------------
   assign prn_data = data_reg;
   assign scsi_data_out = ~data_reg;
   assign prn_data_oe = scsi_io_n;
   assign scsi_data_oe = scsi_io_n;
   assign scsi_sel_n = ~gpo_reg[GPO_SEL_BIT];
   assign prn_strobe_n = ~gpo_reg[GPO_STROBE_BIT];
   assign uart_dcd = 1'b0;
   assign uart_dsr = 1'b0;
   assign uart_cts = 1'b0;

   // ----------------------------------------------------------------
   // Interrupts
   // ----------------------------------------------------------------
   assign pirq = gpo_reg[GPO_PIRQ_EN_BIT] && !prn_busy;
   assign card_irq = pirq || uart_irq;
   assign irq_n = ~card_irq;

   // ----------------------------------------------------------------
   // RAM window and ROM
   // ----------------------------------------------------------------
   assign ram_addr = {gpo_reg[GPO_HI_ADDR_LSB +: GPO_HI_ADDR_W], page_reg,
                      host_addr[7:0]};
   assign ram_sel = acc && region == MHL_WIN
                    && gpo_reg[GPO_RAM_EN_BIT];
   assign ram_wr = host_wr && ram_sel;
   assign ram_wdata = host_wdata;
   assign led_on = gpo_reg[GPO_RAM_EN_BIT];
   assign rom_bank_sel = rom_sel_reg[ROM_SEL_LSB +: ROM_SEL_W];
   assign rom_addr = host_addr[ROM_LSB-1:0];

   // Refresh timer runs on the card clock regardless of host clock
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         ref_cnt_reg <= '0;
      else if (ref_cnt_reg == REFRESH_CNT_W'(REFRESH_CYC - 1))
         ref_cnt_reg <= '0;
      else
         ref_cnt_reg <= ref_cnt_reg + 1'b1;
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         row_reg <= '0;
      else if (ram_refresh)
         row_reg <= row_reg + 1'b1;
   end

   assign ram_refresh = ref_cnt_reg == REFRESH_CNT_W'(REFRESH_CYC - 1)
                        && !(ram_sel && host_clk_present);
   assign ram_refresh_row = row_reg;

   // ----------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         rdata_reg <= 8'h00;
      else if (host_rd && region == MHL_LATCH)
      begin
         if (rsel == 2'h0)
            rdata_reg <= page_reg;
         else if (rsel == 2'h1)
            rdata_reg <= ~scsi_data_in;
         else if (rsel == 2'h2)
            rdata_reg <= {scsi_req_n, prn_busy, scsi_bsy_n, prn_fault_n,
                          1'b0, scsi_io_n, scsi_msg_n, scsi_cd_n};
         else
            rdata_reg <= {3'h0, card_irq, pirq, ser_cts, ser_dsr, ser_dcd};
      end
      else if (host_rd && region == MHL_WIN && gpo_reg[GPO_RAM_EN_BIT])
         rdata_reg <= ram_rdata;
      else if (host_rd && rom_hit)
         rdata_reg <= rom_rdata;
      else if (host_rd)
         rdata_reg <= 8'hff;
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         rvalid_reg <= 1'b0;
      else
         rvalid_reg <= host_rd;
   end

   // UART reads come from the sub-block's own register
   logic uart_last_reg;
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         uart_last_reg <= 1'b0;
      else if (host_rd)
         uart_last_reg <= region == MHL_UART;
   end

   assign host_rdata = uart_last_reg ? uart_rdata : rdata_reg;
   assign host_rdata_valid = rvalid_reg;

   mhl_uart_regs u_uart
   (
      .clk_sys(clk_sys),
      .rst(rst),
      .wr(uart_wr),
      .rd(uart_rd),
      .sel(rsel),
      .wdata(host_wdata),
      .rx_data(uart_rx_data),
      .status_in(uart_status),
      .irq_set(uart_event),
      .rdata(uart_rdata),
      .tx_load(uart_tx_load),
      .prog_reset(uart_prog_reset),
      .irq(uart_irq)
   );

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   property p_rst_on_read;
      @(posedge clk_sys) disable iff (rst)
      host_rd && region == MHL_LATCH && rsel == 2'h0 |=> !scsi_rst_n;
   endproperty
   a_rst_on_read: assert property (p_rst_on_read)
      else $error("bus reset not asserted");

   property p_rst_release;
      @(posedge clk_sys) disable iff (rst)
      host_rd && region == MHL_LATCH && rsel == 2'h2 |=> scsi_rst_n;
   endproperty
   a_rst_release: assert property (p_rst_release)
      else $error("bus reset not released");

   property p_oe;
      @(posedge clk_sys) disable iff (rst)
      scsi_data_oe == scsi_io_n && prn_data_oe == scsi_io_n;
   endproperty
   a_oe: assert property (p_oe)
      else $error("data enable wrong");

   property p_page;
      @(posedge clk_sys) disable iff (rst)
      host_wr && region == MHL_LATCH && rsel == 2'h0
      |=> ram_addr[15:8] == $past(host_wdata);
   endproperty
   a_page: assert property (p_page)
      else $error("page latch not loaded");

   property p_data;
      @(posedge clk_sys) disable iff (rst)
      host_wr && region == MHL_LATCH && rsel == 2'h1
      |=> prn_data == $past(host_wdata) && scsi_data_out == ~prn_data;
   endproperty
   a_data: assert property (p_data)
      else $error("data latch wrong");

   property p_data_read;
      @(posedge clk_sys) disable iff (rst)
      host_rd && region == MHL_LATCH && rsel == 2'h1
      |=> host_rdata == ~$past(scsi_data_in);
   endproperty
   a_data_read: assert property (p_data_read)
      else $error("data read not inverted");

   sequence s_data_access;
      acc && region == MHL_LATCH && rsel == 2'h1;
   endsequence
   property p_ack;
      @(posedge clk_sys) disable iff (rst)
      scsi_req_n && !(acc && region == MHL_LATCH && rsel == 2'h1)
      |=> scsi_ack_n;
   endproperty
   a_ack: assert property (p_ack)
      else $error("ack not released");

   property p_ack_set;
      @(posedge clk_sys) disable iff (rst)
      s_data_access |=> !scsi_ack_n;
   endproperty
   a_ack_set: assert property (p_ack_set)
      else $error("ack not asserted");

   property p_pirq;
      @(posedge clk_sys) disable iff (rst)
      gpo_reg[GPO_PIRQ_EN_BIT] && !prn_busy |-> !irq_n;
   endproperty
   a_pirq: assert property (p_pirq)
      else $error("printer irq missing");

   property p_ram_gate;
      @(posedge clk_sys) disable iff (rst)
      ram_sel |-> led_on && region == MHL_WIN;
   endproperty
   a_ram_gate: assert property (p_ram_gate)
      else $error("ram access not gated");
endmodule
`default_nettype wire

/* File: mhl_scsi_target.sv */
// SCSI target model that answers the card's ACK with REQ
`timescale 1ns/1ps
`default_nettype none
module mhl_scsi_target
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic slow,
   input wire logic scsi_ack_n,
   input wire logic [7:0] scsi_data_out,
   input wire logic scsi_data_oe,
   input wire logic [7:0] tgt_byte,
   output logic scsi_req_n,
   output logic [7:0] scsi_data_in
);
   logic [2:0] wait_reg;
   // Pin level: the card drives while enabled, the target otherwise
   assign scsi_data_in = scsi_data_oe ? scsi_data_out : tgt_byte;
   // REQ goes high after ACK is seen, low again once ACK drops
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         wait_reg <= 3'h0;
         scsi_req_n <= 1'b0;
      end
      else if (!scsi_ack_n && !scsi_req_n)
      begin
         wait_reg <= wait_reg + 3'h1;
         if (wait_reg == (slow ? 3'h5 : 3'h0))
            scsi_req_n <= 1'b1;
      end
      else if (scsi_ack_n)
      begin
         wait_reg <= 3'h0;
         scsi_req_n <= 1'b0;
      end
   end
endmodule
`default_nettype wire

/* File: mhl_latch_bank_bench.sv */
// Testbench for the host latch bank
`timescale 1ns/1ps
`default_nettype none
module mhl_latch_bank_bench;
   import mhl_pkg::*;
   logic clk_sys, rst, host_clk_present, host_rd, host_wr, host_rdata_valid;
   logic scsi_data_oe, prn_data_oe, scsi_cd_n, scsi_msg_n, scsi_io_n;
   logic scsi_bsy_n, scsi_req_n, scsi_ack_n, scsi_rst_n, scsi_sel_n;
   logic prn_strobe_n, prn_busy, prn_fault_n, ser_dcd, ser_dsr, ser_cts;
   logic uart_dcd, uart_dsr, uart_cts, uart_event, uart_tx_load, ram_sel;
   logic ram_wr, ram_refresh, led_on, irq_n, slow, s_sel, s_wr;
   logic [15:0] host_addr;
   logic [7:0] host_wdata, host_rdata, scsi_data_in, scsi_data_out, prn_data;
   logic [7:0] uart_rx_data, uart_status, ram_rdata, rom_rdata, tgt, rd, ex;
   logic [19:0] ram_addr, s_addr;
   logic [3:0] rom_bank_sel;
   logic [10:0] rom_addr, s_rom;
   logic [8:0] ram_refresh_row, s_row;
   logic [7:0] ram_wdata, s_wd;
   logic uart_prog_reset;
   int fail_count = 0;
   int tests_run = 0;
   int cyc = 0;
   int n, txn, refn, prgn;

   mhl_latch_bank uut (.clk_sys, .rst, .host_clk_present, .host_addr,
      .host_rd, .host_wr, .host_wdata, .host_rdata, .host_rdata_valid,
      .scsi_data_in, .scsi_data_out, .scsi_data_oe, .prn_data, .prn_data_oe,
      .scsi_cd_n, .scsi_msg_n, .scsi_io_n, .scsi_bsy_n, .scsi_req_n,
      .scsi_ack_n, .scsi_rst_n, .scsi_sel_n, .prn_strobe_n, .prn_busy,
      .prn_fault_n, .ser_dcd, .ser_dsr, .ser_cts, .uart_dcd, .uart_dsr,
      .uart_cts, .uart_rx_data, .uart_status, .uart_event, .uart_tx_load,
      .uart_prog_reset, .ram_addr, .ram_sel, .ram_wr, .ram_wdata,
      .ram_rdata, .ram_refresh, .ram_refresh_row, .led_on, .rom_bank_sel,
      .rom_addr, .rom_rdata, .irq_n);

   mhl_scsi_target target (.clk_sys, .rst, .slow, .scsi_ack_n,
      .scsi_data_out, .scsi_data_oe, .tgt_byte(tgt), .scsi_req_n,
      .scsi_data_in);

   initial
   begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end

   // ----------------------------------------------------------------
   // Pulse counters and hang guard
   // ----------------------------------------------------------------
   always @(posedge clk_sys)
   begin
      cyc++;
      if (uart_tx_load === 1'b1)
         txn++;
      if (ram_refresh === 1'b1)
         refn++;
      if (uart_prog_reset === 1'b1)
         prgn++;
      if (cyc == 5000)
      begin
         fail_count++;
         summarize();
      end
   end

   // ----------------------------------------------------------------
   // Compare, access and report tasks
   // ----------------------------------------------------------------
   task automatic chk_a(input logic [19:0] got, input logic [19:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         fail_count++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_b(input logic [7:0] got, input logic [7:0] exp);
      chk_a({12'h000, got}, {12'h000, exp});
   endtask

   task automatic chk_f(input logic got, input logic exp);
      chk_a({19'h00000, got}, {19'h00000, exp});
   endtask

   task automatic acc(input logic w, input logic [15:0] a,
                      input logic [7:0] d);
      @(posedge clk_sys);
      host_wr <= w;
      host_rd <= !w;
      host_addr <= a;
      host_wdata <= d;
      #1;
      s_sel = ram_sel;
      s_wr = ram_wr;
      s_wd = ram_wdata;
      s_addr = ram_addr;
      s_rom = rom_addr;
      @(posedge clk_sys);
      host_wr <= 1'b0;
      host_rd <= 1'b0;
      #1;
      n = 0;
      while (!w && host_rdata_valid !== 1'b1 && n < 4)
      begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      rd = host_rdata;
      if (w)
      begin
         @(posedge clk_sys);
         #1;
      end
   endtask

   // Waits for ACK to be released, n counts the cycles
   task automatic wait_ack;
      n = 0;
      while (scsi_ack_n !== 1'b1 && n < 12)
      begin
         @(posedge clk_sys);
         #1;
         n++;
      end
   endtask

   task automatic summarize;
      $display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial
   begin
      {host_rd, host_wr, scsi_msg_n, prn_fault_n, ser_dsr} = '0;
      {uart_event, slow, host_addr, host_wdata} = '0;
      {scsi_cd_n, scsi_io_n, scsi_bsy_n, prn_busy, host_clk_present} = '1;
      {rst, ser_dcd, ser_cts} = '1;
      {uart_rx_data, uart_status} = 16'h5a91;
      {ram_rdata, rom_rdata, tgt} = 24'h9e6b3c;
      repeat (3) @(posedge clk_sys);
      #1;
      chk_f(scsi_rst_n, 1'b0);
      ex = {scsi_sel_n, prn_strobe_n, led_on, irq_n, rom_bank_sel};
      chk_b(ex, 8'hd0);
      @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      #1;
      chk_f(scsi_rst_n, 1'b0);
      for (int i = 0; i < 2; i++)
      begin
         acc(1'b0, RAM_PAGE_LOW_AND_BUS_RESET, 8'h00);
         chk_f(scsi_rst_n, 1'b0);
         {scsi_cd_n, scsi_msg_n, scsi_bsy_n, prn_fault_n, prn_busy} <=
            i ? 5'h0a : 5'h15;
         acc(1'b0, i ? 16'hd1fe : GENERAL_OUT_IN, 8'h00);
         ex = {scsi_req_n, prn_busy, scsi_bsy_n, prn_fault_n, 1'b0,
               scsi_io_n, scsi_msg_n, scsi_cd_n};
         chk_b(rd, ex);
         chk_f(scsi_rst_n, 1'b1);
      end
      // Data write with a slow target, then a read with pins released
      slow <= 1'b1;
      acc(1'b1, PORT_DATA, 8'h55);
      chk_b({prn_data[3:0], scsi_data_out[3:0]}, 8'h5a);
      chk_f(scsi_data_oe & prn_data_oe & !scsi_ack_n, 1'b1);
      wait_ack();
      chk_f(n > 3 && scsi_ack_n === 1'b1, 1'b1);
      slow <= 1'b0;
      scsi_io_n <= 1'b0;
      acc(1'b1, PORT_DATA, 8'h0f);
      chk_b(prn_data, 8'h0f);
      chk_f(scsi_data_oe | prn_data_oe, 1'b0);
      wait_ack();
      acc(1'b0, PORT_DATA, 8'h00);
      chk_b(rd, ~tgt);
      chk_f(scsi_ack_n, 1'b0);
      wait_ack();
      scsi_io_n <= 1'b1;
      // RAM window: refused while disabled, then full address
      acc(1'b1, RAM_PAGE_LOW_AND_BUS_RESET, 8'h12);
      acc(1'b1, GENERAL_OUT_IN, 8'h05);
      acc(1'b0, RAM_WINDOW_BASE | 16'h0034, 8'h00);
      chk_f(s_sel | led_on, 1'b0);
      chk_b(rd, 8'hff);
      acc(1'b1, GENERAL_OUT_IN, 8'h25);
      chk_f(led_on, 1'b1);
      acc(1'b0, RAM_WINDOW_BASE | 16'h0034, 8'h00);
      chk_a(s_addr, 20'h51234);
      chk_b(rd, ram_rdata);
      acc(1'b1, RAM_WINDOW_BASE | 16'h00c7, 8'h3e);
      chk_f(s_sel & s_wr, 1'b1);
      chk_b(s_wd, 8'h3e);
      acc(1'b1, GENERAL_OUT_IN, 8'h50);
      chk_b({scsi_sel_n, prn_strobe_n, led_on}, 8'h00);
      // Printer interrupt, then serial interrupt
      prn_busy <= 1'b1;
      acc(1'b1, GENERAL_OUT_IN, 8'h80);
      chk_f(irq_n, 1'b1);
      prn_busy <= 1'b0;
      acc(1'b0, ROM_SELECT_AND_IRQ_SENSE, 8'h00);
      chk_f(irq_n, 1'b0);
      chk_b(rd, {3'h0, 2'h3, ser_cts, ser_dsr, ser_dcd});
      chk_b({uart_dcd, uart_dsr, uart_cts}, 8'h00);
      acc(1'b1, GENERAL_OUT_IN, 8'h00);
      chk_f(irq_n, 1'b1);
      @(posedge clk_sys);
      uart_event <= 1'b1;
      @(posedge clk_sys);
      uart_event <= 1'b0;
      acc(1'b0, 16'hd1ff, 8'h00);
      chk_b(rd, {3'h0, 2'h2, ser_cts, ser_dsr, ser_dcd});
      acc(1'b0, UART_RESET_AND_STATUS, 8'h00);
      chk_b(rd, uart_status);
      chk_f(irq_n, 1'b1);
      acc(1'b0, 16'hd1c8, 8'h00);
      chk_b(rd, uart_rx_data);
      acc(1'b1, UART_COMMAND, 8'h4b);
      acc(1'b0, 16'hd1da, 8'h00);
      chk_b(rd, 8'h4b);
      txn = 0;
      prgn = 0;
      acc(1'b1, UART_DATA_PORT, 8'h21);
      chk_b(txn[7:0], 8'h01);
      acc(1'b1, UART_RESET_AND_STATUS, 8'h00);
      chk_b({txn[3:0], prgn[3:0]}, 8'h11);
      // Every ROM bank and the disabled case
      for (int i = 0; i < 5; i++)
      begin
         ex = (i < 4) ? (8'h04 << i) : 8'h00;
         acc(1'b1, ROM_SELECT_AND_IRQ_SENSE, ex);
         chk_b({4'h0, rom_bank_sel}, ex >> 2);
         acc(1'b0, ROM_WINDOW_BASE | 16'h07a5, 8'h00);
         chk_b(rd, (i < 4) ? rom_rdata : 8'hff);
      end
      chk_a({9'h000, s_rom}, 20'h007a5);
      // Refresh goes on with the host clock absent
      host_clk_present <= 1'b0;
      @(posedge clk_sys);
      #1;
      refn = 0;
      s_row = ram_refresh_row;
      repeat (2 * REFRESH_CYC) @(posedge clk_sys);
      #1;
      chk_b(refn[7:0], 8'h02);
      chk_a({11'h000, ram_refresh_row - s_row}, 20'h00002);
      host_clk_present <= 1'b1;
      // Reset in mid-run clears the latches again
      acc(1'b1, GENERAL_OUT_IN, 8'he0);
      acc(1'b1, ROM_SELECT_AND_IRQ_SENSE, 8'h10);
      @(posedge clk_sys);
      rst <= 1'b1;
      @(posedge clk_sys);
      #1;
      ex = {scsi_sel_n, prn_strobe_n, led_on, irq_n, rom_bank_sel};
      chk_b(ex, 8'hd0);
      chk_f(scsi_rst_n, 1'b0);
      summarize();
   end
endmodule
`default_nettype wire
